/* hdl/dmcp_map.svh */
`ifndef DMCP_MAP_SVH
`define DMCP_MAP_SVH

// Register map
`define DMCP_MODE_CTRL_ADDR 8'h01
`define DMCP_MODE_CTRL_RST 8'h01
`define DMCP_BIT_CAL 7
`define DMCP_BIT_MUTE 6
`define DMCP_SEL_HI 5
`define DMCP_SEL_LO 1
`define DMCP_BIT_PDN 0

// Mode select field layout
`define DMCP_SEL_CLK_HI 1
`define DMCP_SEL_CLK_LO 0
`define DMCP_SEL_DEEMPH 2
`define DMCP_SEL_FMT_HI 4
`define DMCP_SEL_FMT_LO 3

// Control port framing; chip address value is arbitrary
`define DMCP_CHIP_ADDR 7'h10
`define DMCP_BYTE_LAST 3'h7
`define DMCP_IDX_ADDR 2'h0
`define DMCP_IDX_MAP 2'h1
`define DMCP_IDX_DATA 2'h2

// Mute ramp lengths in left/right clock periods
`define DMCP_RAMP_LEN_M0 1152
`define DMCP_RAMP_LEN_M1 2304
`define DMCP_RAMP_LEN_M2 4608

// Calibration duration in clock cycles
`define DMCP_CAL_CYCLES 12'h400

// Master clock to left/right clock ratios per clock mode
`define DMCP_RATIO_A0 12'h100
`define DMCP_RATIO_A1 12'h180
`define DMCP_RATIO_A2 12'h200
`define DMCP_RATIO_A3 12'h300
`define DMCP_RATIO_B0 12'h080
`define DMCP_RATIO_B1 12'h0c0
`define DMCP_RATIO_B2 12'h100
`define DMCP_RATIO_B3 12'h180
`define DMCP_RATIO_C0 12'h040
`define DMCP_RATIO_C1 12'h060
`define DMCP_RATIO_C2 12'h080
`define DMCP_RATIO_C3 12'h0c0

// De-emphasis rate classification in clock cycles per sample
`define DMCP_CLK_HZ 20000000
`define DMCP_FS_EDGE_32_44 38050
`define DMCP_FS_EDGE_44_48 46050
`define DMCP_PER_32_44 (`DMCP_CLK_HZ / `DMCP_FS_EDGE_32_44)
`define DMCP_PER_44_48 (`DMCP_CLK_HZ / `DMCP_FS_EDGE_44_48)
`define DMCP_CNT_MAX 12'hfff

`endif

/* hdl/dmcp_pkg.sv */
package dmcp_pkg;
  typedef enum logic [1:0] {
    DMCP_RAMP_IDLE = 2'b00,
    DMCP_RAMP_DOWN = 2'b01,
    DMCP_RAMP_MUTED = 2'b10,
    DMCP_RAMP_UP = 2'b11
  } dmcp_ramp_e;
  typedef enum logic [1:0] {
    DMCP_FS_32K = 2'b00,
    DMCP_FS_44K1 = 2'b01,
    DMCP_FS_48K = 2'b10
  } dmcp_fs_e;
  typedef logic [12:0] dmcp_pos_t;
endpackage : dmcp_pkg

/* hdl/dmcp_ramp_if.sv */
`timescale 1ns/1ps
interface dmcp_ramp_if;
  logic mute_req;
  logic [1:0] clk_mode;
  logic lr_tick;
  logic fully_muted;
  logic busy;
  dmcp_pkg::dmcp_pos_t pos;
  modport ctl (output mute_req, output clk_mode, output lr_tick,
    input fully_muted, input busy, input pos);
  modport ramp (input mute_req, input clk_mode, input lr_tick,
    output fully_muted, output busy, output pos);
endinterface : dmcp_ramp_if

/* hdl/dmcp_ramp.sv */
`timescale 1ns/1ps
`include "dmcp_map.svh"
module dmcp_ramp #(
  parameter dmcp_pkg::dmcp_pos_t LEN_M0 = 13'(`DMCP_RAMP_LEN_M0),
  parameter dmcp_pkg::dmcp_pos_t LEN_M1 = 13'(`DMCP_RAMP_LEN_M1),
  parameter dmcp_pkg::dmcp_pos_t LEN_M2 = 13'(`DMCP_RAMP_LEN_M2)
) (
  input wire logic clk,
  input wire logic rst,
  dmcp_ramp_if.ramp rif
);
  dmcp_pkg::dmcp_ramp_e state_ff;
  dmcp_pkg::dmcp_ramp_e nxt_state;
  dmcp_pkg::dmcp_pos_t pos_ff;
  dmcp_pkg::dmcp_pos_t nxt_pos;
  dmcp_pkg::dmcp_pos_t len;

  // Ramp length per clock mode
  always_comb begin
    case (rif.clk_mode)
      2'h0: len = LEN_M0;
      2'h1: len = LEN_M1;
      default: len = LEN_M2;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    case (state_ff)
      dmcp_pkg::DMCP_RAMP_IDLE: begin
        nxt_pos = '0;
        if (rif.mute_req) begin
          nxt_state = dmcp_pkg::DMCP_RAMP_DOWN;
        end
      end
      dmcp_pkg::DMCP_RAMP_DOWN: begin
        if (!rif.mute_req) begin
          nxt_state = dmcp_pkg::DMCP_RAMP_UP;
        end else if (rif.lr_tick) begin
          nxt_pos = pos_ff + 13'h1;
          if (pos_ff + 13'h1 >= len) begin
            nxt_pos = len;
            nxt_state = dmcp_pkg::DMCP_RAMP_MUTED;
          end
        end
      end
      dmcp_pkg::DMCP_RAMP_MUTED: begin
        if (!rif.mute_req) begin
          nxt_state = dmcp_pkg::DMCP_RAMP_UP;
        end
      end
      dmcp_pkg::DMCP_RAMP_UP: begin
        if (rif.mute_req) begin
          nxt_state = dmcp_pkg::DMCP_RAMP_DOWN;
        end else if (rif.lr_tick) begin
          if (pos_ff <= 13'h1) begin
            nxt_pos = '0;
            nxt_state = dmcp_pkg::DMCP_RAMP_IDLE;
          end else begin
            nxt_pos = pos_ff - 13'h1;
          end
        end
      end
      default: begin
        nxt_state = dmcp_pkg::DMCP_RAMP_IDLE;
        nxt_pos = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= dmcp_pkg::DMCP_RAMP_IDLE;
      pos_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
    end
  end

  assign rif.fully_muted = (state_ff == dmcp_pkg::DMCP_RAMP_MUTED);
  assign rif.busy = (state_ff == dmcp_pkg::DMCP_RAMP_DOWN) ||
    (state_ff == dmcp_pkg::DMCP_RAMP_UP);
  assign rif.pos = pos_ff;
endmodule : dmcp_ramp

/* hdl/dmcp_top.sv */
`timescale 1ns/1ps
`include "dmcp_map.svh"
module dmcp_top #(
  parameter dmcp_pkg::dmcp_pos_t RAMP_LEN_M2 = 13'(`DMCP_RAMP_LEN_M2)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic control_serial_clock,
  input wire logic control_data_in,
  output logic control_data_out,
  output logic control_data_out_oe,
  input wire logic left_right_clock,
  output logic mute_indicator_out,
  output logic power_down_out,
  output logic calibration_active_out,
  output logic deemph_enable_out,
  output logic [1:0] deemph_rate_out,
  output logic [1:0] audio_format_out,
  output logic [1:0] clock_mode_out,
  output logic mute_ramp_busy_out,
  output logic [12:0] mute_ramp_pos_out
);
  // Pin synchronisers
  logic cs_n_s1_ff;
  logic cs_n_s2_ff;
  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic din_s1_ff;
  logic din_s2_ff;
  logic left_right_clock_s1_ff;
  logic left_right_clock_s2_ff;
  logic sclk_prev_ff;
  logic left_right_clock_prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_n_s1_ff <= 1'b1;
      cs_n_s2_ff <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
      left_right_clock_s1_ff <= 1'b0;
      left_right_clock_s2_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      left_right_clock_prev_ff <= 1'b0;
    end else begin
      cs_n_s1_ff <= chip_select_n;
      cs_n_s2_ff <= cs_n_s1_ff;
      sclk_s1_ff <= control_serial_clock;
      sclk_s2_ff <= sclk_s1_ff;
      din_s1_ff <= control_data_in;
      din_s2_ff <= din_s1_ff;
      left_right_clock_s1_ff <= left_right_clock;
      left_right_clock_s2_ff <= left_right_clock_s1_ff;
      sclk_prev_ff <= sclk_s2_ff;
      left_right_clock_prev_ff <= left_right_clock_s2_ff;
    end
  end

  logic sel_active;
  logic sclk_rise;
  logic sclk_fall;
  logic lr_tick;
  assign sel_active = !cs_n_s2_ff;
  assign sclk_rise = sel_active && sclk_s2_ff && !sclk_prev_ff;
  assign sclk_fall = sel_active && !sclk_s2_ff && sclk_prev_ff;
  assign lr_tick = left_right_clock_s2_ff && !left_right_clock_prev_ff;

  // Control port framing
  logic [2:0] bit_cnt_ff;
  logic [1:0] byte_idx_ff;
  logic [7:0] shift_in_ff;
  logic [7:0] shift_out_ff;
  logic [7:0] map_ff;
  logic rw_ff;
  logic addr_ok_ff;
  logic control_data_out_ff;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] ctrl_reg_ff;
  logic [7:0] rd_data;

  assign rx_byte = {shift_in_ff[6:0], din_s2_ff};
  assign byte_done = sclk_rise && (bit_cnt_ff == `DMCP_BYTE_LAST);
  assign rd_data = (map_ff == `DMCP_MODE_CTRL_ADDR) ? ctrl_reg_ff : 8'h00;

  always_ff @(posedge clk) begin
    if (rst || !sel_active) begin
      bit_cnt_ff <= 3'h0;
      byte_idx_ff <= `DMCP_IDX_ADDR;
      shift_in_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ok_ff <= 1'b0;
    end else if (sclk_rise) begin
      shift_in_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done) begin
        if (byte_idx_ff != `DMCP_IDX_DATA) begin
          byte_idx_ff <= byte_idx_ff + 2'h1;
        end
        if (byte_idx_ff == `DMCP_IDX_ADDR) begin
          addr_ok_ff <= (rx_byte[7:1] == `DMCP_CHIP_ADDR);
          rw_ff <= rx_byte[0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      map_ff <= 8'h00;
    end else if (byte_done && addr_ok_ff && !rw_ff && byte_idx_ff == `DMCP_IDX_MAP) begin
      map_ff <= rx_byte;
    end
  end

  // Read data shifts out MSB first after falling edges
  logic load_rd;
  assign load_rd = byte_done && byte_idx_ff == `DMCP_IDX_ADDR &&
    rx_byte[0] && (rx_byte[7:1] == `DMCP_CHIP_ADDR);

  always_ff @(posedge clk) begin
    if (rst || !sel_active) begin
      shift_out_ff <= 8'h00;
      control_data_out_ff <= 1'b0;
    end else if (load_rd) begin
      shift_out_ff <= rd_data;
    end else if (sclk_fall && addr_ok_ff && rw_ff && byte_idx_ff != `DMCP_IDX_ADDR) begin
      control_data_out_ff <= shift_out_ff[7];
      shift_out_ff <= {shift_out_ff[6:0], shift_out_ff[7]};
    end
  end

  assign control_data_out = control_data_out_ff;
  assign control_data_out_oe = sel_active && addr_ok_ff && rw_ff &&
    (byte_idx_ff != `DMCP_IDX_ADDR);

  // Mode control register
  logic reg_wr;
  logic cal_done;
  assign reg_wr = byte_done && addr_ok_ff && !rw_ff &&
    byte_idx_ff == `DMCP_IDX_DATA && map_ff == `DMCP_MODE_CTRL_ADDR;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg_ff <= `DMCP_MODE_CTRL_RST;
    end else if (reg_wr) begin
      ctrl_reg_ff <= rx_byte;
    end else if (cal_done) begin
      ctrl_reg_ff[`DMCP_BIT_CAL] <= 1'b0;
    end
  end

  // Offset calibration sequencer
  logic [11:0] cal_cnt_ff;
  logic cal_run_ff;
  assign cal_done = cal_run_ff && (cal_cnt_ff == `DMCP_CAL_CYCLES);

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_run_ff <= 1'b0;
      cal_cnt_ff <= 12'h000;
    end else if (reg_wr && rx_byte[`DMCP_BIT_CAL]) begin
      cal_run_ff <= 1'b1;
      cal_cnt_ff <= 12'h000;
    end else if (cal_done) begin
      cal_run_ff <= 1'b0;
      cal_cnt_ff <= 12'h000;
    end else if (cal_run_ff) begin
      cal_cnt_ff <= cal_cnt_ff + 12'h001;
    end
  end

  // Mode select decode
  logic [4:0] mode_sel;
  logic [1:0] clk_mode;
  assign mode_sel = ctrl_reg_ff[`DMCP_SEL_HI:`DMCP_SEL_LO];
  assign clk_mode = mode_sel[`DMCP_SEL_CLK_HI:`DMCP_SEL_CLK_LO];

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_mode_out <= 2'h0;
      audio_format_out <= 2'h0;
      deemph_enable_out <= 1'b0;
      power_down_out <= 1'b1;
      calibration_active_out <= 1'b0;
    end else begin
      clock_mode_out <= clk_mode;
      audio_format_out <= mode_sel[`DMCP_SEL_FMT_HI:`DMCP_SEL_FMT_LO];
      deemph_enable_out <= mode_sel[`DMCP_SEL_DEEMPH] && (clk_mode == 2'h0);
      power_down_out <= ctrl_reg_ff[`DMCP_BIT_PDN];
      calibration_active_out <= cal_run_ff;
    end
  end

  // Left/right period measurement
  logic [11:0] per_cnt_ff;
  logic ratio_bad_ff;
  logic ratio_ok;
  always_comb begin
    case (clk_mode)
      2'h0: ratio_ok = per_cnt_ff == `DMCP_RATIO_A0 || per_cnt_ff == `DMCP_RATIO_A1 ||
        per_cnt_ff == `DMCP_RATIO_A2 || per_cnt_ff == `DMCP_RATIO_A3;
      2'h1: ratio_ok = per_cnt_ff == `DMCP_RATIO_B0 || per_cnt_ff == `DMCP_RATIO_B1 ||
        per_cnt_ff == `DMCP_RATIO_B2 || per_cnt_ff == `DMCP_RATIO_B3;
      2'h2: ratio_ok = per_cnt_ff == `DMCP_RATIO_C0 || per_cnt_ff == `DMCP_RATIO_C1 ||
        per_cnt_ff == `DMCP_RATIO_C2 || per_cnt_ff == `DMCP_RATIO_C3;
      default: ratio_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      per_cnt_ff <= 12'h001;
      ratio_bad_ff <= 1'b1;
      deemph_rate_out <= dmcp_pkg::DMCP_FS_44K1;
    end else if (lr_tick) begin
      per_cnt_ff <= 12'h001;
      ratio_bad_ff <= !ratio_ok;
      if (per_cnt_ff >= 12'(`DMCP_PER_32_44)) begin
        deemph_rate_out <= dmcp_pkg::DMCP_FS_32K;
      end else if (per_cnt_ff >= 12'(`DMCP_PER_44_48)) begin
        deemph_rate_out <= dmcp_pkg::DMCP_FS_44K1;
      end else begin
        deemph_rate_out <= dmcp_pkg::DMCP_FS_48K;
      end
    end else if (per_cnt_ff != `DMCP_CNT_MAX) begin
      per_cnt_ff <= per_cnt_ff + 12'h001;
    end else begin
      ratio_bad_ff <= 1'b1;
    end
  end

  // Soft mute ramp
  dmcp_ramp_if rif ();
  assign rif.mute_req = ctrl_reg_ff[`DMCP_BIT_MUTE];
  assign rif.clk_mode = clk_mode;
  assign rif.lr_tick = lr_tick;

  dmcp_ramp #(
    .LEN_M0(13'(`DMCP_RAMP_LEN_M0)),
    .LEN_M1(13'(`DMCP_RAMP_LEN_M1)),
    .LEN_M2(RAMP_LEN_M2)
  ) u_ramp (
    .clk(clk),
    .rst(rst),
    .rif(rif.ramp)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      mute_indicator_out <= 1'b0;
      mute_ramp_busy_out <= 1'b0;
      mute_ramp_pos_out <= 13'h0000;
    end else begin
      mute_indicator_out <= !(rif.fully_muted || ctrl_reg_ff[`DMCP_BIT_PDN] ||
        ratio_bad_ff);
      mute_ramp_busy_out <= rif.busy;
      mute_ramp_pos_out <= rif.pos;
    end
  end
endmodule : dmcp_top

/* sim/dmcp_top_sva.sv */
`timescale 1ns/1ps
module dmcp_top_sva #(
  parameter dmcp_pkg::dmcp_pos_t RAMP_LEN_M2 = 13'h1200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic control_serial_clock,
  input wire logic control_data_in,
  input wire logic control_data_out,
  input wire logic control_data_out_oe,
  input wire logic left_right_clock,
  input wire logic mute_indicator_out,
  input wire logic power_down_out,
  input wire logic calibration_active_out,
  input wire logic deemph_enable_out,
  input wire logic [1:0] deemph_rate_out,
  input wire logic [1:0] audio_format_out,
  input wire logic [1:0] clock_mode_out,
  input wire logic mute_ramp_busy_out,
  input wire logic [12:0] mute_ramp_pos_out
);
  logic [11:0] cal_cnt_ff;
  // Cycles spent calibrating
  always_ff @(posedge clk) begin
    if (rst || !calibration_active_out) begin
      cal_cnt_ff <= 12'h000;
    end else begin
      cal_cnt_ff <= cal_cnt_ff + 12'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_state: assert property (disable iff (1'b0) rst |=> power_down_out &&
    !mute_indicator_out && !calibration_active_out && !mute_ramp_busy_out)
    else $error("state not cleared by reset");
  a_pdn_mutes: assert property (power_down_out [*3] |-> !mute_indicator_out)
    else $error("indicator high while powered down");
  a_rise_powered: assert property ($rose(mute_indicator_out) |-> !power_down_out)
    else $error("indicator released while powered down");
  a_cal_length: assert property ($fell(calibration_active_out) |->
    cal_cnt_ff >= 12'h3fc && cal_cnt_ff <= 12'h404)
    else $error("calibration length wrong");
  a_ramp_step: assert property ($changed(mute_ramp_pos_out) |->
    mute_ramp_pos_out == $past(mute_ramp_pos_out) + 13'h0001 ||
    mute_ramp_pos_out == $past(mute_ramp_pos_out) - 13'h0001)
    else $error("ramp moved more than one step");
  a_pos_hold: assert property (!mute_ramp_busy_out && !$past(mute_ramp_busy_out)
    |-> $stable(mute_ramp_pos_out)) else $error("ramp moved while idle");
  a_dout_timing: assert property (control_data_out_oe && $past(control_data_out_oe) &&
    $changed(control_data_out) |-> !$past(control_serial_clock) &&
    !$past(control_serial_clock, 2)) else $error("read data changed outside clock low");
  a_oe_select: assert property (chip_select_n [*4] |-> !control_data_out_oe)
    else $error("read data driven while deselected");
  a_deemph_mode: assert property (deemph_enable_out |-> clock_mode_out == 2'h0)
    else $error("de-emphasis outside clock mode 0");
  a_muted_depth: assert property (clock_mode_out == 2'h2 && !mute_ramp_busy_out &&
    mute_ramp_pos_out != 13'h0000 |-> mute_ramp_pos_out == RAMP_LEN_M2)
    else $error("mode 2 ramp stopped at wrong depth");
  c_cal_done: cover property ($fell(calibration_active_out));
  c_ramp_done: cover property ($fell(mute_ramp_busy_out));
  c_unmuted: cover property ($rose(mute_indicator_out));
endmodule : dmcp_top_sva

/* sim/dmcp_host.sv */
`timescale 1ns/1ps
`include "dmcp_map.svh"
module dmcp_host (
  input wire logic clk,
  output logic chip_select_n,
  output logic control_serial_clock,
  output logic control_data_in,
  input wire logic control_data_out,
  input wire logic control_data_out_oe
);
  initial begin
    chip_select_n = 1'b1;
    control_serial_clock = 1'b0;
    control_data_in = 1'b0;
  end
  // One byte, MSB first, clock low and high 4 cycles each
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      control_data_in <= tx[i];
      repeat (4) @(posedge clk);
      control_serial_clock <= 1'b1;
      rx[i] = control_data_out_oe ? control_data_out : 1'bx;
      repeat (4) @(posedge clk);
      control_serial_clock <= 1'b0;
    end
  endtask : xbyte
  task frame(input logic [7:0] b0, input logic [7:0] b1, input int nb,
    input logic [7:0] b2, output logic [7:0] rx);
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    xbyte(b0, rx);
    xbyte(b1, rx);
    if (nb > 2) xbyte(b2, rx);
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    control_data_in <= ~control_data_in;
    repeat (24) @(posedge clk);
  endtask : frame
  task wr(input logic [7:0] map, input logic [7:0] d);
    logic [7:0] rx;
    frame({`DMCP_CHIP_ADDR, 1'b0}, map, 3, d, rx);
  endtask : wr
  task rd(input logic [7:0] map, output logic [7:0] d);
    frame({`DMCP_CHIP_ADDR, 1'b0}, map, 2, 8'h00, d);
    frame({`DMCP_CHIP_ADDR, 1'b1}, 8'h00, 2, 8'h00, d);
  endtask : rd
endmodule : dmcp_host

/* sim/dac_mode_control_port_test.sv */
`timescale 1ns/1ps
module dac_mode_control_port_test;
  logic clk, rst, chip_select_n, control_serial_clock, control_data_in, left_right_clock;
  logic control_data_out, control_data_out_oe, mute_indicator_out, power_down_out;
  logic calibration_active_out, deemph_enable_out, mute_ramp_busy_out;
  logic [1:0] deemph_rate_out, audio_format_out, clock_mode_out;
  logic [12:0] mute_ramp_pos_out;
  int num_errors = 0;
  int checked = 0;
  int lr_half = 200;
  time t_busy = 0;
  localparam dmcp_pkg::dmcp_pos_t LEN2 = 13'h0008;
  localparam logic [4:0] SEL_TBL [4] = '{5'h04, 5'h1b, 5'h06, 5'h12};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Sample clock, free phase against clk
  initial begin
    left_right_clock = 1'b0;
    #13;
    forever #(lr_half) left_right_clock = ~left_right_clock;
  end
  dmcp_top #(.RAMP_LEN_M2(LEN2)) uut (.clk, .rst, .chip_select_n, .control_serial_clock,
    .control_data_in, .control_data_out, .control_data_out_oe, .left_right_clock,
    .mute_indicator_out, .power_down_out, .calibration_active_out, .deemph_enable_out,
    .deemph_rate_out, .audio_format_out, .clock_mode_out, .mute_ramp_busy_out,
    .mute_ramp_pos_out);
  dmcp_host host (.clk, .chip_select_n, .control_serial_clock, .control_data_in,
    .control_data_out, .control_data_out_oe);
  // Ramp start time stamp
  always @(posedge mute_ramp_busy_out) t_busy = $time;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Bounded wait: 0 busy, 1 calibration, 2 indicator
  task wait_lvl(input int sel, input logic lvl, input int lim);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      v = sel == 0 ? mute_ramp_busy_out : sel == 1 ? calibration_active_out : mute_indicator_out;
      n++;
    end while (v !== lvl && n < lim);
    if (v !== lvl) begin
      check(v, lvl);
      stop_test();
    end
  endtask : wait_lvl
  task t_reset;
    logic [7:0] r;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(power_down_out, 1'b1);
    check(mute_indicator_out, 1'b0);
    host.rd(8'h01, r);
    check(r, 8'h01);
    $display("t_reset done");
  endtask : t_reset
  task t_modes;
    logic [7:0] r;
    logic [4:0] s;
    for (int i = 0; i < 4; i++) begin
      s = SEL_TBL[i];
      host.wr(8'h01, {2'b00, s, 1'b0});
      repeat (3) @(posedge clk);
      #1;
      check(audio_format_out, s[4:3]);
      check(clock_mode_out, s[1:0]);
      check(deemph_enable_out, s[2] && s[1:0] == 2'h0);
      host.rd(8'h01, r);
      check(r, {2'b00, s, 1'b0});
    end
    host.wr(8'h01, 8'h08);
    host.wr(8'h02, 8'hff);
    host.rd(8'h02, r);
    check(r, 8'h00);
    host.rd(8'h01, r);
    check(r, 8'h08);
    check(deemph_rate_out, 2'h2);
    $display("t_modes done");
  endtask : t_modes
  task t_cal;
    logic [7:0] r;
    host.wr(8'h01, 8'h80);
    check(calibration_active_out, 1'b1);
    host.rd(8'h01, r);
    check(r, 8'h80);
    wait_lvl(1, 1'b0, 1100);
    host.rd(8'h01, r);
    check(r, 8'h00);
    $display("t_cal done");
  endtask : t_cal
  task t_ramp(input logic [1:0] m, input int len);
    int dt;
    for (int up = 0; up < 2; up++) begin
      host.wr(8'h01, {1'b0, up == 0, 3'b000, m, 1'b0});
      wait_lvl(0, 1'b1, 20);
      wait_lvl(0, 1'b0, len * 8 + 100);
      dt = ($time - t_busy) / 50;
      check(dt > len * 8 - 12 && dt <= len * 8 + 4, 1'b1);
      check(mute_ramp_pos_out, up == 0 ? len : 0);
      check(mute_indicator_out, 1'b0);
    end
    $display("t_ramp done mode %0d", m);
  endtask : t_ramp
  task t_indicator;
    lr_half = 1600;
    host.wr(8'h01, 8'h04);
    wait_lvl(2, 1'b1, 1000);
    check(mute_indicator_out, 1'b1);
    host.wr(8'h01, 8'h44);
    wait_lvl(0, 1'b1, 20);
    check(mute_indicator_out, 1'b1);
    wait_lvl(0, 1'b0, 700);
    repeat (3) @(posedge clk);
    #1;
    check(mute_indicator_out, 1'b0);
    host.wr(8'h01, 8'h04);
    repeat (3) @(posedge clk);
    #1;
    check(mute_indicator_out, 1'b1);
    check(mute_ramp_busy_out, 1'b1);
    host.wr(8'h01, 8'h05);
    repeat (3) @(posedge clk);
    #1;
    check(power_down_out, 1'b1);
    check(mute_indicator_out, 1'b0);
    lr_half = 6400;
    host.wr(8'h01, 8'h00);
    wait_lvl(2, 1'b1, 1500);
    check(mute_indicator_out, 1'b1);
    lr_half = 200;
    $display("t_indicator done");
  endtask : t_indicator
  initial begin
    rst = 1'b1;
    t_reset();
    t_modes();
    t_cal();
    t_ramp(2'h0, 1152);
    t_ramp(2'h1, 2304);
    t_ramp(2'h2, 8);
    t_indicator();
    t_reset();
    stop_test();
  end
endmodule : dac_mode_control_port_test
bind dmcp_top dmcp_top_sva #(.RAMP_LEN_M2(RAMP_LEN_M2)) u_sva (.clk, .rst, .chip_select_n,
  .control_serial_clock, .control_data_in, .control_data_out, .control_data_out_oe,
  .left_right_clock, .mute_indicator_out, .power_down_out, .calibration_active_out,
  .deemph_enable_out, .deemph_rate_out, .audio_format_out, .clock_mode_out,
  .mute_ramp_busy_out, .mute_ramp_pos_out);
